// ### pmppg_consts.vh
// Constants for the pulse-measure / pulse-generator timer.
// Included by the timer module; definitions only.
`ifndef PMPPG_CONSTS_VH
`define PMPPG_CONSTS_VH

// Register offsets (byte-wide register port)
`define PMPPG_OFF_CTRL 4'h0
`define PMPPG_OFF_PERL 4'h1
`define PMPPG_OFF_PERH 4'h2
`define PMPPG_OFF_DUTL 4'h3
`define PMPPG_OFF_DUTH 4'h4
`define PMPPG_OFF_CNTL 4'h5
`define PMPPG_OFF_CNTH 4'h6
`define PMPPG_OFF_CFG 4'h7
`define PMPPG_OFF_STAT 4'h8

// Control register fields
`define PMPPG_CTRL_PRESET_BIT 7
`define PMPPG_CTRL_DBLEDGE_BIT 6
`define PMPPG_CTRL_START_HI 5
`define PMPPG_CTRL_START_LO 4
`define PMPPG_CTRL_CLK_HI 3
`define PMPPG_CTRL_CLK_LO 2
`define PMPPG_CTRL_MODE_HI 1
`define PMPPG_CTRL_MODE_LO 0
`define PMPPG_CTRL_RST 8'h00

// Start field codes
`define PMPPG_START_STOP 2'h0
`define PMPPG_START_SW 2'h1
`define PMPPG_START_EXT 2'h2

// Mode codes
`define PMPPG_MODE_MEAS 2'h1
`define PMPPG_MODE_PPG 2'h2

// Config register fields
`define PMPPG_CFG_POL_BIT 0
`define PMPPG_CFG_MASK_BIT 1
`define PMPPG_CFG_RST 8'h00

// Prescaler divide ratios (source clock select 0..3), as terminal counts (ratio minus one)
`define PMPPG_PRE_W 6
`define PMPPG_PRE_SEL0 6'h00
`define PMPPG_PRE_SEL1 6'h03
`define PMPPG_PRE_SEL2 6'h0F
`define PMPPG_PRE_SEL3 6'h3F

// Compare ignore window after a high-byte write: one 40 ns machine cycle in clocks
`define PMPPG_IGNORE_CYC 4'h4

`define PMPPG_CNT_RST 16'h0000
`define PMPPG_REG_RST 16'h0000

`endif

// ### pmppg_timer.v
// 16-bit pulse-width measurement and programmable pulse generator timer.
// Assumes a byte register port synchronous to clk and a synchronous timer input pin.
//
// Overview of operation
// - Measurement mode starts counting on selected trigger edge, using prescaled tick.
// - Measurement: first opposite edge copies counter to duty register, raises match irq.
// - Single-edge capture clears counter at the opposite-edge capture.
// - Double-edge capture keeps counting, captures again on next trigger edge.
// - Polarity from polarity select; single/double from control bit 6.
// - Generator starts on selected pin edge or software command, internal clock.
// - Generator toggles output flip-flop when counter equals duty register; a count matching both duty and period leaves it.
// - Generator duty match raises irq only while mid-match mask is zero.
// - Period match toggles flip-flop again, clears counter, raises irq.
// - Toggle flip-flop clears to zero on reset.
// - Control bit 7 presets the toggle flip-flop, choosing output polarity.
// - Duty register writes are ignored unless generator mode is selected.
// - Low-byte write inhibits compare until high byte; then ignore one machine cycle.
`timescale 1ns/1ns
`include "pmppg_consts.vh"

module pmppg_timer (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Register port
	input wire [3:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [7:0] regRdData,
	// Timer input pin
	input wire timerPin,
	// Generator output and interrupt pulse
	output reg pulseGenOut,
	output reg timerMatchIrq
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_RUN = 3'b100;

// Software-visible registers
reg [7:0] ctrl_r;
reg [7:0] cfg_r;
reg [15:0] period_r;
reg [15:0] duty_r;

// Counter and run control
reg [15:0] cnt_r;
reg [2:0] state_r;
reg [2:0] state_nxt;

// Source clock divider
reg [`PMPPG_PRE_W-1:0] pre_r;
reg tick_r;

// Pin history and compare gating
reg pinPrev_r;
reg inhibit_r;
reg [3:0] ignore_r;
reg stepped_r;
reg secondEdge_r;

wire [1:0] startField = ctrl_r[`PMPPG_CTRL_START_HI:`PMPPG_CTRL_START_LO];
wire [1:0] modeField = ctrl_r[`PMPPG_CTRL_MODE_HI:`PMPPG_CTRL_MODE_LO];
wire [1:0] clkSel = ctrl_r[`PMPPG_CTRL_CLK_HI:`PMPPG_CTRL_CLK_LO];
wire dblEdge = ctrl_r[`PMPPG_CTRL_DBLEDGE_BIT];
wire polFall = cfg_r[`PMPPG_CFG_POL_BIT];
wire midMask = cfg_r[`PMPPG_CFG_MASK_BIT];
wire isMeas = (modeField == `PMPPG_MODE_MEAS);
wire isPpg = (modeField == `PMPPG_MODE_PPG);
wire stopped = (startField != `PMPPG_START_SW) && (startField != `PMPPG_START_EXT);

wire wrEn = regWrStb;
wire wrCtrl = wrEn && (regAddr == `PMPPG_OFF_CTRL);
wire wrPerL = wrEn && (regAddr == `PMPPG_OFF_PERL);
wire wrPerH = wrEn && (regAddr == `PMPPG_OFF_PERH);
wire wrDutL = wrEn && (regAddr == `PMPPG_OFF_DUTL) && isPpg;
wire wrDutH = wrEn && (regAddr == `PMPPG_OFF_DUTH) && isPpg;
wire wrCfg = wrEn && (regAddr == `PMPPG_OFF_CFG);

////////////////////////////////////////////////////////////////////////////////
// Pin edge detection

wire riseEdge = timerPin && !pinPrev_r;
wire fallEdge = !timerPin && pinPrev_r;
wire trigEdge = polFall ? fallEdge : riseEdge;
wire oppEdge = polFall ? riseEdge : fallEdge;

// Reset value equals the pin's idle low level, so no false edge follows reset
always @(posedge clk) begin
	if (!rst_n) begin
		pinPrev_r <= 1'b0;
	end else begin
		pinPrev_r <= timerPin;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Prescaler: free-running, tick is a one-cycle enable

// Free-running: the first tick after a start may come early by up to one period
reg [`PMPPG_PRE_W-1:0] preLimit;

always @* begin
	case (clkSel)
		2'h0: preLimit = `PMPPG_PRE_SEL0;
		2'h1: preLimit = `PMPPG_PRE_SEL1;
		2'h2: preLimit = `PMPPG_PRE_SEL2;
		default: preLimit = `PMPPG_PRE_SEL3;
	endcase
end

always @(posedge clk) begin
	if (!rst_n) begin
		pre_r <= {`PMPPG_PRE_W{1'b0}};
		tick_r <= 1'b0;
	end else if (pre_r >= preLimit) begin
		pre_r <= {`PMPPG_PRE_W{1'b0}};
		tick_r <= 1'b1;
	end else begin
		pre_r <= pre_r + 1'b1;
		tick_r <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Compare gating after compare-register writes

// A low byte alone must never arm a compare against a half-updated value
wire cmpEn = !inhibit_r && (ignore_r == 4'h0);

always @(posedge clk) begin
	if (!rst_n) begin
		inhibit_r <= 1'b0;
		ignore_r <= 4'h0;
	end else if (wrPerH || wrDutH) begin
		inhibit_r <= 1'b0;
		ignore_r <= `PMPPG_IGNORE_CYC;
	end else if (wrPerL || wrDutL) begin
		inhibit_r <= 1'b1;
	end else if (ignore_r != 4'h0) begin
		ignore_r <= ignore_r - 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Run control state machine

wire startHit = (startField == `PMPPG_START_SW && isPpg) ||
	(startField == `PMPPG_START_EXT && trigEdge);

// Measurement with a software start stays in WAIT: it needs a pin edge
always @* begin
	state_nxt = state_r;
	case (state_r)
		ST_IDLE: begin
			if (!stopped && (isMeas || isPpg)) begin
				state_nxt = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (stopped) begin
				state_nxt = ST_IDLE;
			end else if (startHit && (isPpg || startField == `PMPPG_START_EXT)) begin
				state_nxt = ST_RUN;
			end
		end
		ST_RUN: begin
			if (stopped) begin
				state_nxt = ST_IDLE;
			end else if (isMeas && !dblEdge && oppEdge) begin
				state_nxt = ST_WAIT;
			end
		end
		default: state_nxt = ST_IDLE;
	endcase
end

always @(posedge clk) begin
	if (!rst_n) begin
		state_r <= ST_IDLE;
	end else begin
		state_r <= state_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Counter, capture and generator matches

// Matches are judged the cycle after a step, so each count value matches once
wire running = (state_r == ST_RUN);
wire measOpp = running && isMeas && oppEdge && !secondEdge_r;
wire measTrig = running && isMeas && dblEdge && trigEdge && secondEdge_r;
wire dutyHit = running && isPpg && stepped_r && cmpEn && (cnt_r == duty_r);
wire periodHit = running && isPpg && stepped_r && cmpEn && (cnt_r == period_r);

always @(posedge clk) begin
	if (!rst_n) begin
		cnt_r <= `PMPPG_CNT_RST;
		stepped_r <= 1'b0;
		secondEdge_r <= 1'b0;
	end else if (!running) begin
		cnt_r <= `PMPPG_CNT_RST;
		stepped_r <= 1'b0;
		secondEdge_r <= 1'b0;
	end else if (measOpp) begin
		secondEdge_r <= dblEdge;
		stepped_r <= 1'b0;
		if (!dblEdge) begin
			cnt_r <= `PMPPG_CNT_RST;
		end else if (tick_r) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end else if (measTrig) begin
		secondEdge_r <= 1'b0;
		stepped_r <= 1'b0;
		cnt_r <= `PMPPG_CNT_RST;
	end else if (periodHit) begin
		cnt_r <= `PMPPG_CNT_RST;
		stepped_r <= 1'b0;
	end else if (tick_r) begin
		cnt_r <= cnt_r + 16'h0001;
		stepped_r <= 1'b1;
	end else begin
		stepped_r <= 1'b0;
	end
end

// Duty register doubles as the capture register
always @(posedge clk) begin
	if (!rst_n) begin
		duty_r <= `PMPPG_REG_RST;
	end else if (measOpp || measTrig) begin
		duty_r <= cnt_r;
	end else if (wrDutL) begin
		duty_r[7:0] <= regWrData;
	end else if (wrDutH) begin
		duty_r[15:8] <= regWrData;
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		period_r <= `PMPPG_REG_RST;
	end else if (wrPerL) begin
		period_r[7:0] <= regWrData;
	end else if (wrPerH) begin
		period_r[15:8] <= regWrData;
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		ctrl_r <= `PMPPG_CTRL_RST;
	end else if (wrCtrl) begin
		ctrl_r <= regWrData;
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		cfg_r <= `PMPPG_CFG_RST;
	end else if (wrCfg) begin
		cfg_r <= regWrData;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Toggle flip-flop and interrupt pulse

always @(posedge clk) begin
	if (!rst_n) begin
		pulseGenOut <= 1'b0;
	end else if (wrCtrl) begin
		pulseGenOut <= regWrData[`PMPPG_CTRL_PRESET_BIT];
	end else if (dutyHit != periodHit) begin
		pulseGenOut <= !pulseGenOut;
	end
end

// Registered so the pulse is free of glitches and lasts one clock per matching cycle
always @(posedge clk) begin
	if (!rst_n) begin
		timerMatchIrq <= 1'b0;
	end else begin
		timerMatchIrq <= measOpp || measTrig || periodHit || (dutyHit && !midMask);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port: data valid the cycle after the strobe; control is write-only

reg [7:0] rdData_nxt;

// Zero when idle keeps a shared read bus quiet between accesses
always @* begin
	rdData_nxt = 8'h00;
	if (regRdStb) begin
		case (regAddr)
			`PMPPG_OFF_DUTL: rdData_nxt = duty_r[7:0];
			`PMPPG_OFF_DUTH: rdData_nxt = duty_r[15:8];
			`PMPPG_OFF_CNTL: rdData_nxt = cnt_r[7:0];
			`PMPPG_OFF_CNTH: rdData_nxt = cnt_r[15:8];
			`PMPPG_OFF_CFG: rdData_nxt = cfg_r;
			`PMPPG_OFF_STAT: rdData_nxt = {4'h0, inhibit_r, running, secondEdge_r, pulseGenOut};
			default: rdData_nxt = 8'h00;
		endcase
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		regRdData <= 8'h00;
	end else begin
		regRdData <= rdData_nxt;
	end
end

endmodule

// ### pmppg_timer_assertions.sv
// Port checker for the pulse measure / generator timer.
// Assumes ctrl and cfg change only by writes seen on the register port.
`timescale 1ns/1ns
module pmppg_timer_chk (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Register port
	input wire [3:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	input wire [7:0] regRdData,
	// Pins
	input wire timerPin,
	input wire pulseGenOut,
	input wire timerMatchIrq
);
	reg [7:0] ctlSh_r;
	reg [7:0] cfgSh_r;
	reg [1:0] quiet_r;
	wire ctlWr = regWrStb && regAddr == 4'h0;
	wire stop = ctlSh_r[5:4] == 2'h0 || ctlSh_r[5:4] == 2'h3;
	wire pulse_generator_output = ctlSh_r[1:0] == 2'h2 && !stop;
	wire meas = ctlSh_r[1:0] == 2'h1 && !stop;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Shadow only gates; a stop needs three cycles to drain the pipeline
	always @(posedge clk) begin
		if (!rst_n) begin
			ctlSh_r <= 8'h00;
			cfgSh_r <= 8'h00;
		end else if (ctlWr)
			ctlSh_r <= regWrData;
		else if (regWrStb && regAddr == 4'h7)
			cfgSh_r <= regWrData;
	end
	always @(posedge clk) begin
		if (!rst_n || !stop)
			quiet_r <= 2'h0;
		else if (quiet_r != 2'h3)
			quiet_r <= quiet_r + 2'h1;
	end
	////////////////////////////////////////
	property p_preset;
		ctlWr |=> pulseGenOut == $past(regWrData[7]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not loaded");
	property p_rdIdle;
		!regRdStb |=> regRdData == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_wrOnly;
		regRdStb && regAddr < 4'h3 |=> regRdData == 8'h00;
	endproperty
	a_wrOnly: assert property (p_wrOnly) else $error("write-only reg read back");
	property p_stopIrq;
		quiet_r == 2'h3 |-> !timerMatchIrq;
	endproperty
	a_stopIrq: assert property (p_stopIrq) else $error("irq while stopped");
	property p_stopHold;
		quiet_r == 2'h3 && !$past(ctlWr) |-> $stable(pulseGenOut);
	endproperty
	a_stopHold: assert property (p_stopHold) else $error("output moved while stopped");
	property p_ppgToggle;
		pulse_generator_output && !cfgSh_r[1] && !$past(ctlWr)
			|-> timerMatchIrq == (pulseGenOut != $past(pulseGenOut));
	endproperty
	a_ppgToggle: assert property (p_ppgToggle) else $error("toggle and irq apart");
	property p_maskIrq;
		pulse_generator_output && cfgSh_r[1] && timerMatchIrq |-> pulseGenOut == ctlSh_r[7];
	endproperty
	a_maskIrq: assert property (p_maskIrq) else $error("masked duty irq");
	property p_measEdge;
		meas && timerMatchIrq |-> $past(timerPin) != $past(timerPin, 2)
			|| $past(timerPin, 2) != $past(timerPin, 3);
	endproperty
	a_measEdge: assert property (p_measEdge) else $error("capture without edge");
endmodule
bind pmppg_timer pmppg_timer_chk i_pmppg_timer_chk (.clk(clk), .rst_n(rst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
	.regRdData(regRdData), .timerPin(timerPin), .pulseGenOut(pulseGenOut),
	.timerMatchIrq(timerMatchIrq));

// ### pmppg_pulse_src.sv
// External pulse source on the timer input pin.
// Assumes the pin is push-pull, so it never floats.
`timescale 1ns/1ns
module pmppg_pulse_src (
	// Clock
	input wire clk,
	// Shape in clocks, high and low lasting one more than given
	input wire run,
	input wire [7:0] hiCyc,
	input wire [7:0] loCyc,
	// Pin
	output reg timerPin
);
	reg [7:0] cnt_r = 8'h00;
	initial timerPin = 1'b0;
	always @(posedge clk) begin
		if (!run || cnt_r == 8'h00) begin
			cnt_r <= timerPin ? loCyc : hiCyc;
			timerPin <= run && !timerPin;
		end else begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule

// ### test_pmppg_timer.sv
// Self-checking bench for the timer, generator and measurement modes.
// Assumes the pulse source model drives the timer pin.
`timescale 1ns/1ns
module test_pmppg_timer;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [3:0] regAddr = 4'h0;
	reg [7:0] regWrData = 8'h00;
	reg regWrStb = 1'b0;
	reg regRdStb = 1'b0;
	wire [7:0] regRdData;
	wire timerPin;
	wire pulseGenOut;
	wire timerMatchIrq;
	reg run = 1'b0;
	reg [7:0] hiCyc = 8'h10;
	reg [7:0] loCyc = 8'h10;
	reg [7:0] rd8;
	reg [15:0] v16;
	reg [15:0] c1;
	integer seed = 32'h6F4D94F6;
	integer miscompares = 0;
	integer checked = 0;
	integer i, p, d, t0;
	always #5 clk = ~clk;
	pmppg_timer i_pmppg_timer (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .timerPin(timerPin), .pulseGenOut(pulseGenOut),
		.timerMatchIrq(timerMatchIrq));
	pmppg_pulse_src i_pmppg_pulse_src (.clk(clk), .run(run), .hiCyc(hiCyc),
		.loCyc(loCyc), .timerPin(timerPin));
	////////////////////////////////////////
	function [15:0] near(input [15:0] a, input [15:0] b);
		near = (a + 16'h0001 >= b) && (a <= b + 16'h0001);
	endfunction
	task end_sim;
		begin
			$display("miscompares %0d checked %0d", miscompares, checked);
			if (miscompares == 0 && checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] v);
		begin
			regAddr <= a;
			regWrData <= v;
			regWrStb <= 1'b1;
			@(posedge clk);
			regWrStb <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [3:0] a);
		begin
			regAddr <= a;
			regRdStb <= 1'b1;
			@(posedge clk);
			regRdStb <= 1'b0;
			#1 rd8 = regRdData;
			@(posedge clk);
		end
	endtask
	task rd16(input [3:0] a);
		begin
			rd(a);
			v16[7:0] = rd8;
			rd(a + 4'h1);
			v16[15:8] = rd8;
		end
	endtask
	// Waits for an irq, or for a generator fall when fall is set
	task wt(input fall);
		integer k;
		begin
			k = 0;
			do begin
				@(posedge clk);
				#1 k = k + 1;
			end while ((fall ? pulseGenOut !== 1'b0 : timerMatchIrq !== 1'b1) && k < 9000);
			if (k >= 9000) begin
				miscompares = miscompares + 1;
				end_sim;
			end
		end
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(4'h8);
		check(rd8, 8'h00);
		rd(4'h1);
		check(rd8, 8'h00);
		wr(4'h0, 8'h80);
		rd(4'h8);
		check(rd8[0], 1'b1);
		wr(4'h0, 8'h01);
		wr(4'h3, 8'h5A);
		wr(4'h4, 8'hA5);
		rd16(4'h3);
		check(v16, 16'h0000);
		wr(4'h0, 8'h02);
		wr(4'h1, 8'h05);
		rd(4'h8);
		check(rd8[3], 1'b1);
		wr(4'h2, 8'h00);
		rd(4'h8);
		check(rd8[3], 1'b0);
		for (i = 0; i < 8; i = i + 1) begin
			p = 2 + {$random(seed)} % 5;
			d = 1 + {$random(seed)} % (p - 1);
			wr(4'h0, 8'h02);
			wr(4'h1, p[7:0]);
			wr(4'h2, 8'h00);
			wr(4'h3, d[7:0]);
			wr(4'h4, 8'h00);
			wr(4'h7, {6'h00, i[2], 1'b0});
			wr(4'h0, {4'h9, i[1:0], 2'h2});
			wt(1'b1);
			t0 = $time;
			wt(1'b0);
			check(($time - t0) / 10, (p - d) << (2 * i[1:0]));
			check(pulseGenOut, 1'b1);
			wr(4'h0, 8'h00);
		end
		for (i = 0; i < 4; i = i + 1) begin
			hiCyc <= 8'h08 + {$random(seed)} % 32;
			loCyc <= 8'h08 + {$random(seed)} % 32;
			wr(4'h7, {7'h00, i[1]});
			wr(4'h0, {1'b0, i[0], 6'h21});
			run <= 1'b1;
			wt(1'b0);
			wt(1'b0);
			rd16(4'h3);
			c1 = v16;
			wt(1'b0);
			rd16(4'h3);
			if (i[0])
				check(near(c1 > v16 ? c1 - v16 : v16 - c1, (i[1] ? hiCyc : loCyc) + 1), 1);
			else
				check(near(v16, (i[1] ? loCyc : hiCyc) + 1), 1);
			run <= 1'b0;
			wr(4'h0, 8'h00);
		end
		end_sim;
	end
endmodule
